// ---- pkg/ssti_regs.svh ----
// Register offsets, field codes and constants of the subtract/swap/interpolate datapath
`ifndef SSTI_REGS_SVH
`define SSTI_REGS_SVH
`define SSTI_OFS_DREG   8'h00
`define SSTI_OFS_AREG   8'h20
`define SSTI_OFS_CCR    8'h40
`define SSTI_OFS_STAT   8'h44
`define SSTI_BANK_MASK  8'he3
`define SSTI_SZ_BYTE    2'h0
`define SSTI_SZ_WORD    2'h1
`define SSTI_SZ_LONG    2'h2
`define SSTI_SZ_BAD     2'h3
`define SSTI_SWAP_PAT   13'h0908
`define SSTI_QSUB_TOP   4'h5
`define SSTI_XSUB_TOP   4'h9
`define SSTI_TBL_TOP    10'h3e0
`define SSTI_MODE_DREG  3'h0
`define SSTI_MODE_AREG  3'h1
`define SSTI_MODE_PREDC 3'h4
`define SSTI_MODE_EXT   3'h7
`define SSTI_ABS_LONG   3'h1
`define SSTI_PC_INDEX   3'h3
`define SSTI_QUICK_8    32'h8
`define SSTI_ROUND_HALF 42'h80
`define SSTI_CCR_RST    5'h00
`endif

// ---- pkg/ssti_pkg.sv ----
// Types shared by the subtract/swap/interpolate datapath
package ssti_pkg;
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } ssti_ccr_t;
  typedef struct packed {
    logic [15:0] op;
    logic [15:0] ext;
    logic [31:0] ea;
  } ssti_cmd_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  size;
    logic        we;
    logic [31:0] wdata;
  } ssti_mem_cmd_t;
  typedef struct packed {
    logic [31:0] res;
    logic        n;
    logic        z;
    logic        v;
    logic        c;
  } ssti_alu_t;
  typedef enum logic [2:0] {
    SSTI_ST_IDLE   = 3'b000,
    SSTI_ST_RD_SRC = 3'b001,
    SSTI_ST_RD_DST = 3'b010,
    SSTI_ST_EXEC   = 3'b011,
    SSTI_ST_WR     = 3'b100
  } ssti_state_t;
  typedef enum logic [1:0] {
    SSTI_OP_QSUB = 2'b00,
    SSTI_OP_XSUB = 2'b01,
    SSTI_OP_TBL  = 2'b10
  } ssti_op_t;
endpackage : ssti_pkg

// ---- hdl/ssti_interp.sv ----
// Signed linear interpolation between two entries, rounded or unrounded
`timescale 1ns/100ps
`include "ssti_regs.svh"
module ssti_interp
  import ssti_pkg::*;
(
  input  wire logic [31:0] entry_lo,
  input  wire logic [31:0] entry_hi,
  input  wire logic [31:0] old_dest,
  input  wire logic [7:0]  frac,
  input  wire logic [1:0]  size,
  input  wire logic        round_off,
  output ssti_alu_t        res
);
  logic signed [32:0] e0;
  logic signed [32:0] e1;
  logic signed [32:0] diff;
  logic signed [41:0] prod;
  logic signed [41:0] full;
  logic        [41:0] mag;
  logic        [41:0] qv;
  logic        [41:0] rnd;

  always_comb
  begin
    if (size == `SSTI_SZ_BYTE)
    begin
      e0 = {{25{entry_lo[7]}}, entry_lo[7:0]};
      e1 = {{25{entry_hi[7]}}, entry_hi[7:0]};
    end
    else if (size == `SSTI_SZ_WORD)
    begin
      e0 = {{17{entry_lo[15]}}, entry_lo[15:0]};
      e1 = {{17{entry_hi[15]}}, entry_hi[15:0]};
    end
    else
    begin
      e0 = {entry_lo[31], entry_lo};
      e1 = {entry_hi[31], entry_hi};
    end
    diff = e1 - e0;
    // Widen before the multiply so long differences keep every product bit
    prod = 42'(diff) * 42'($signed({1'b0, frac}));
    full = 42'($signed({{9{e0[32]}}, e0} <<< 8) + prod);
    // Halves round away from zero, matching the symmetric adjustment table
    mag = prod[41] ? 42'(-prod) : prod;
    qv = (mag + `SSTI_ROUND_HALF) >> 8;
    rnd = 42'({{9{e0[32]}}, e0} + (prod[41] ? 42'(-qv) : qv));
    res.c = 1'b0;
    if (!round_off)
    begin
      res.v = 1'b0;
      if (size == `SSTI_SZ_BYTE)
      begin
        res.res = {old_dest[31:8], rnd[7:0]};
        res.n = rnd[7];
        res.z = rnd[7:0] == 8'h00;
      end
      else if (size == `SSTI_SZ_WORD)
      begin
        res.res = {old_dest[31:16], rnd[15:0]};
        res.n = rnd[15];
        res.z = rnd[15:0] == 16'h0000;
      end
      else
      begin
        res.res = rnd[31:0];
        res.n = rnd[31];
        res.z = rnd[31:0] == 32'h00000000;
      end
    end
    else
    begin
      // Byte and word results fit, so the low word is already sign extended
      res.res = full[31:0];
      res.n = full[31];
      res.z = full[31:0] == 32'h00000000;
      res.v = (size == `SSTI_SZ_LONG) && (full[41:31] != {11{full[31]}});
    end
  end
endmodule : ssti_interp

// ---- hdl/ssti_exec.sv ----
// Datapath for quick/extended subtract, register half swap and signed table interpolation
//
// Behaviour
// - Quick subtract sets all flags, X copies C, except to an address register, which leaves them unchanged
// - Quick data code zero means eight
// - Size 00 byte, 01 word, 10 long
// - Quick subtract accepts only alterable destinations
// - Extended subtract: dest minus source minus X
// - Memory form predecrements both, reads, writes back
// - Extended subtract only clears Z on nonzero
// - Extended subtract sets X, N, V, C
// - Mode bit: register or memory operation
// - Destination field: data or predecrement address
// - Source field: data or predecrement address
// - Swap exchanges register halves
// - Swap flags from 32-bit result, X kept
// - Interpolation from table or register pair
// - Low word: 8.8 fixed-point independent variable
// - Table entry address: base plus index times size
// - Read selected signed entry and the next
// - Difference of entries times fraction
// - Add scaled difference to entry, write result
// - Register mode ignores the integer part
// - Round when R clear, merge at size
// - Unrounded: fraction low, integer above, extended
// - Interpolation flags: X kept, C cleared, V range
// - Zero address mode selects register pair
`timescale 1ns/100ps
`include "ssti_regs.svh"
module ssti_exec
  import ssti_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          cmd_valid,
  input  wire ssti_cmd_t     cmd,
  output ssti_ccr_t          ccr,
  output logic               busy,
  output logic               done,
  output logic               illegal,
  output logic               mem_req,
  output ssti_mem_cmd_t      mem_cmd,
  input  wire logic          mem_ack,
  input  wire logic [31:0]   mem_rdata,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata
);
  ssti_state_t   state_ff;
  ssti_state_t   nxt_state;
  ssti_op_t      op_ff;
  ssti_ccr_t     ccr_ff;
  ssti_mem_cmd_t mem_cmd_ff;
  logic [31:0]   dreg_ff [8];
  logic [31:0]   areg_ff [8];
  logic [31:0]   addr0_ff;
  logic [31:0]   addr1_ff;
  logic [31:0]   src_ff;
  logic [31:0]   dst_ff;
  logic [1:0]    size_ff;
  logic [2:0]    dsel_ff;
  logic          round_off_ff;
  logic          busy_ff;
  logic          done_ff;
  logic          illegal_ff;
  logic          sticky_illegal_ff;
  logic          mem_req_ff;
  logic [31:0]   reg_rdata_ff;

  logic [2:0]    ea_mode;
  logic [2:0]    ea_reg;
  logic [2:0]    subtract_with_extend_op_dest_field;
  logic [2:0]    subtract_with_extend_op_source_field;
  logic [2:0]    interp_dest_reg;
  logic [1:0]    op_size;
  logic [1:0]    tbl_size;
  logic [31:0]   quick;
  logic [31:0]   sz_bytes;
  logic [31:0]   nxt_addr0;
  logic [31:0]   nxt_addr1;
  logic          is_swap;
  logic          is_qsub;
  logic          is_xsub;
  logic          is_tbl;
  logic          qsub_ok;
  logic          tbl_ok;
  logic          start;
  logic          legal;
  logic          go_mem;
  logic [31:0]   swap_res;
  ssti_alu_t     alu_idle;
  ssti_alu_t     alu_exec;
  ssti_alu_t     interp_res;
  logic [31:0]   ip_lo;
  logic [31:0]   ip_hi;
  logic [31:0]   ip_dest;
  logic [1:0]    ip_size;
  logic          ip_round_off;

  assign ccr = ccr_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign illegal = illegal_ff;
  assign mem_req = mem_req_ff;
  assign mem_cmd = mem_cmd_ff;
  assign reg_rdata = reg_rdata_ff;

  // Operands are left aligned so one 33-bit subtract serves all three sizes
  function automatic ssti_alu_t sub_sized(input logic [31:0] d, input logic [31:0] s,
                                          input logic x, input logic [1:0] sz);
    logic [4:0]  sh;
    logic [31:0] da;
    logic [31:0] sa;
    logic [32:0] r;
    ssti_alu_t   o;
    sh = (sz == `SSTI_SZ_BYTE) ? 5'd24 : ((sz == `SSTI_SZ_WORD) ? 5'd16 : 5'd0);
    da = d << sh;
    sa = s << sh;
    r = {1'b0, da} - {1'b0, sa} - ({32'h0, x} << sh);
    o.res = r[31:0] >> sh;
    o.n = r[31];
    o.z = r[31:0] == 32'h0;
    o.v = (da[31] ^ sa[31]) & (da[31] ^ r[31]);
    o.c = r[32];
    return o;
  endfunction : sub_sized

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                        input logic [1:0] sz);
    if (sz == `SSTI_SZ_BYTE)
      return {old[31:8], nv[7:0]};
    else if (sz == `SSTI_SZ_WORD)
      return {old[31:16], nv[15:0]};
    else
      return nv;
  endfunction : merge

  // Instruction decode
  always_comb
  begin
    ea_mode = cmd.op[5:3];
    ea_reg = cmd.op[2:0];
    subtract_with_extend_op_dest_field = cmd.op[11:9];
    subtract_with_extend_op_source_field = cmd.op[2:0];
    interp_dest_reg = cmd.ext[14:12];
    op_size = cmd.op[7:6];
    tbl_size = cmd.ext[7:6];
    quick = (cmd.op[11:9] == 3'h0) ? `SSTI_QUICK_8 : {29'h0, cmd.op[11:9]};
    is_swap = cmd.op[15:3] == `SSTI_SWAP_PAT;
    is_qsub = (cmd.op[15:12] == `SSTI_QSUB_TOP) && cmd.op[8] && (op_size != `SSTI_SZ_BAD);
    is_xsub = (cmd.op[15:12] == `SSTI_XSUB_TOP) && cmd.op[8] && (cmd.op[5:4] == 2'h0)
              && (op_size != `SSTI_SZ_BAD);
    is_tbl = (cmd.op[15:6] == `SSTI_TBL_TOP) && !cmd.ext[15] && cmd.ext[11] && !cmd.ext[9]
             && (tbl_size != `SSTI_SZ_BAD) && (cmd.ext[5:3] == 3'h0)
             && (cmd.ext[8] == (ea_mode != `SSTI_MODE_DREG));
    // Immediate and pc-relative codes fall out through the extended-mode register check
    unique case (ea_mode)
      `SSTI_MODE_AREG: qsub_ok = op_size != `SSTI_SZ_BYTE;
      `SSTI_MODE_EXT:  qsub_ok = ea_reg <= `SSTI_ABS_LONG;
      default:         qsub_ok = 1'b1;
    endcase
    // Table mode takes control addressing only
    unique case (ea_mode)
      3'h2, 3'h5, 3'h6: tbl_ok = 1'b1;
      `SSTI_MODE_EXT:   tbl_ok = ea_reg <= `SSTI_PC_INDEX;
      `SSTI_MODE_DREG:  tbl_ok = cmd.op[5:3] == 3'h0;
      default:          tbl_ok = 1'b0;
    endcase
    start = cmd_valid && (state_ff == SSTI_ST_IDLE);
    legal = is_swap || (is_qsub && qsub_ok) || is_xsub || (is_tbl && tbl_ok);
    go_mem = (is_qsub && ea_mode > `SSTI_MODE_AREG) || (is_xsub && cmd.op[3])
             || (is_tbl && ea_mode != `SSTI_MODE_DREG);
    sz_bytes = 32'h1 << (is_tbl ? tbl_size : op_size);
  end

  // Next addresses: table entry pair, the two predecremented pointers or the quick-subtract destination
  always_comb
  begin
    nxt_addr0 = addr0_ff;
    nxt_addr1 = addr1_ff;
    if (start && is_tbl)
    begin
      nxt_addr0 = cmd.ea + ({24'h0, dreg_ff[interp_dest_reg][15:8]} << tbl_size);
      nxt_addr1 = nxt_addr0 + sz_bytes;
    end
    else if (start && is_xsub)
    begin
      nxt_addr0 = areg_ff[subtract_with_extend_op_source_field] - sz_bytes;
      // The same pointer named twice steps down twice
      nxt_addr1 = ((subtract_with_extend_op_dest_field == subtract_with_extend_op_source_field) ? nxt_addr0
                   : areg_ff[subtract_with_extend_op_dest_field]) - sz_bytes;
    end
    else if (start && is_qsub)
      nxt_addr1 = cmd.ea;
  end

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      SSTI_ST_IDLE:
        if (start && legal && go_mem)
          nxt_state = (is_qsub) ? SSTI_ST_RD_DST : SSTI_ST_RD_SRC;
      SSTI_ST_RD_SRC:
        if (mem_ack)
          nxt_state = SSTI_ST_RD_DST;
      SSTI_ST_RD_DST:
        if (mem_ack)
          nxt_state = SSTI_ST_EXEC;
      SSTI_ST_EXEC:
        nxt_state = (op_ff == SSTI_OP_TBL) ? SSTI_ST_IDLE : SSTI_ST_WR;
      SSTI_ST_WR:
        if (mem_ack)
          nxt_state = SSTI_ST_IDLE;
      default:
        nxt_state = SSTI_ST_IDLE;
    endcase
  end

  // Arithmetic for the single-cycle register forms and the memory write-back step
  always_comb
  begin
    swap_res = {dreg_ff[ea_reg][15:0], dreg_ff[ea_reg][31:16]};
    if (is_xsub)
      alu_idle = sub_sized(dreg_ff[subtract_with_extend_op_dest_field], dreg_ff[subtract_with_extend_op_source_field],
                           ccr_ff.x, op_size);
    else
      alu_idle = sub_sized(dreg_ff[ea_reg], quick, 1'b0, op_size);
    alu_exec = sub_sized(dst_ff, src_ff, (op_ff == SSTI_OP_XSUB) && ccr_ff.x, size_ff);
    if (state_ff == SSTI_ST_EXEC)
    begin
      ip_lo = src_ff;
      ip_hi = dst_ff;
      ip_dest = dreg_ff[dsel_ff];
      ip_size = size_ff;
      ip_round_off = round_off_ff;
    end
    else
    begin
      ip_lo = dreg_ff[cmd.op[2:0]];
      ip_hi = dreg_ff[cmd.ext[2:0]];
      ip_dest = dreg_ff[interp_dest_reg];
      ip_size = tbl_size;
      ip_round_off = cmd.ext[10];
    end
  end

  ssti_interp u_interp (
    .entry_lo  (ip_lo),
    .entry_hi  (ip_hi),
    .old_dest  (ip_dest),
    .frac      (ip_dest[7:0]),
    .size      (ip_size),
    .round_off (ip_round_off),
    .res       (interp_res)
  );

  // Sequencer and captured operation context
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff <= SSTI_ST_IDLE;
      op_ff <= SSTI_OP_QSUB;
      size_ff <= `SSTI_SZ_BYTE;
      dsel_ff <= 3'h0;
      round_off_ff <= 1'b0;
      addr0_ff <= 32'h0;
      addr1_ff <= 32'h0;
      src_ff <= 32'h0;
      dst_ff <= 32'h0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      addr0_ff <= nxt_addr0;
      addr1_ff <= nxt_addr1;
      if (start && legal && go_mem)
      begin
        op_ff <= is_tbl ? SSTI_OP_TBL : (is_xsub ? SSTI_OP_XSUB : SSTI_OP_QSUB);
        size_ff <= is_tbl ? tbl_size : op_size;
        dsel_ff <= interp_dest_reg;
        round_off_ff <= cmd.ext[10];
        src_ff <= quick;
      end
      if (state_ff == SSTI_ST_RD_SRC && mem_ack)
        src_ff <= mem_rdata;
      if (state_ff == SSTI_ST_RD_DST && mem_ack)
        dst_ff <= mem_rdata;
    end
  end

  // Register file: software port first, so datapath writes in the same cycle win
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 8; i++)
      begin
        dreg_ff[i] <= 32'h0;
        areg_ff[i] <= 32'h0;
      end
    end
    else if (ce)
    begin
      if (reg_wr && !busy_ff && (reg_addr & `SSTI_BANK_MASK) == `SSTI_OFS_DREG)
        dreg_ff[reg_addr[4:2]] <= reg_wdata;
      if (reg_wr && !busy_ff && (reg_addr & `SSTI_BANK_MASK) == `SSTI_OFS_AREG)
        areg_ff[reg_addr[4:2]] <= reg_wdata;
      if (start && legal)
      begin
        if (is_swap)
          dreg_ff[ea_reg] <= swap_res;
        else if (is_qsub && ea_mode == `SSTI_MODE_DREG)
          dreg_ff[ea_reg] <= merge(dreg_ff[ea_reg], alu_idle.res, op_size);
        else if (is_qsub && ea_mode == `SSTI_MODE_AREG)
          areg_ff[ea_reg] <= areg_ff[ea_reg] - quick;
        else if (is_xsub && !cmd.op[3])
          dreg_ff[subtract_with_extend_op_dest_field] <= merge(dreg_ff[subtract_with_extend_op_dest_field], alu_idle.res, op_size);
        else if (is_xsub)
        begin
          areg_ff[subtract_with_extend_op_source_field] <= nxt_addr0;
          areg_ff[subtract_with_extend_op_dest_field] <= nxt_addr1;
        end
        else if (is_tbl && ea_mode == `SSTI_MODE_DREG)
          dreg_ff[interp_dest_reg] <= interp_res.res;
      end
      if (state_ff == SSTI_ST_EXEC && op_ff == SSTI_OP_TBL)
        dreg_ff[dsel_ff] <= interp_res.res;
    end
  end

  // Condition codes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ccr_ff <= `SSTI_CCR_RST;
    else if (ce)
    begin
      if (reg_wr && !busy_ff && reg_addr == `SSTI_OFS_CCR)
        ccr_ff <= reg_wdata[4:0];
      if (start && legal)
      begin
        if (is_swap)
        begin
          ccr_ff.n <= swap_res[31];
          ccr_ff.z <= swap_res == 32'h0;
          ccr_ff.v <= 1'b0;
          ccr_ff.c <= 1'b0;
        end
        else if (is_qsub && ea_mode == `SSTI_MODE_DREG)
          ccr_ff <= {alu_idle.c, alu_idle.n, alu_idle.z, alu_idle.v, alu_idle.c};
        else if (is_xsub && !cmd.op[3])
          ccr_ff <= {alu_idle.c, alu_idle.n, ccr_ff.z & alu_idle.z, alu_idle.v,
                     alu_idle.c};
        else if (is_tbl && ea_mode == `SSTI_MODE_DREG)
          ccr_ff <= {ccr_ff.x, interp_res.n, interp_res.z, interp_res.v, 1'b0};
      end
      if (state_ff == SSTI_ST_EXEC)
      begin
        if (op_ff == SSTI_OP_TBL)
          ccr_ff <= {ccr_ff.x, interp_res.n, interp_res.z, interp_res.v, 1'b0};
        else if (op_ff == SSTI_OP_XSUB)
          ccr_ff <= {alu_exec.c, alu_exec.n, ccr_ff.z & alu_exec.z, alu_exec.v,
                     alu_exec.c};
        else
          ccr_ff <= {alu_exec.c, alu_exec.n, alu_exec.z, alu_exec.v, alu_exec.c};
      end
    end
  end

  // Operand memory port: request held until acknowledged
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mem_req_ff <= 1'b0;
      mem_cmd_ff <= '0;
    end
    else if (ce)
    begin
      mem_req_ff <= (nxt_state == SSTI_ST_RD_SRC) || (nxt_state == SSTI_ST_RD_DST)
                    || (nxt_state == SSTI_ST_WR);
      mem_cmd_ff.addr <= (nxt_state == SSTI_ST_RD_SRC) ? nxt_addr0 : nxt_addr1;
      mem_cmd_ff.size <= (state_ff == SSTI_ST_IDLE) ? (is_tbl ? tbl_size : op_size) : size_ff;
      mem_cmd_ff.we <= nxt_state == SSTI_ST_WR;
      if (state_ff == SSTI_ST_EXEC)
        mem_cmd_ff.wdata <= alu_exec.res;
    end
  end

  // Handshake status toward the decoder
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
      sticky_illegal_ff <= 1'b0;
    end
    else if (ce)
    begin
      busy_ff <= nxt_state != SSTI_ST_IDLE;
      done_ff <= (start && legal && !go_mem)
                 || (state_ff == SSTI_ST_EXEC && op_ff == SSTI_OP_TBL)
                 || (state_ff == SSTI_ST_WR && mem_ack);
      illegal_ff <= start && !legal;
      // A new reject wins over a clear in the same cycle
      if (start && !legal)
        sticky_illegal_ff <= 1'b1;
      else if (reg_wr && reg_addr == `SSTI_OFS_STAT && reg_wdata[1])
        sticky_illegal_ff <= 1'b0;
    end
  end

  // Software read port, data one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reg_rdata_ff <= 32'h0;
    else if (ce)
    begin
      reg_rdata_ff <= 32'h0;
      if (reg_rd && (reg_addr & `SSTI_BANK_MASK) == `SSTI_OFS_DREG)
        reg_rdata_ff <= dreg_ff[reg_addr[4:2]];
      else if (reg_rd && (reg_addr & `SSTI_BANK_MASK) == `SSTI_OFS_AREG)
        reg_rdata_ff <= areg_ff[reg_addr[4:2]];
      else if (reg_rd && reg_addr == `SSTI_OFS_CCR)
        reg_rdata_ff <= {27'h0, ccr_ff};
      else if (reg_rd && reg_addr == `SSTI_OFS_STAT)
        reg_rdata_ff <= {30'h0, sticky_illegal_ff, busy_ff};
    end
  end
endmodule : ssti_exec

// ---- testbench/ssti_exec_asserts.sv ----
// Port-level assertions for the subtract/swap/interpolate datapath
`timescale 1ns/100ps
module ssti_exec_asserts
  import ssti_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          ce,
  input wire logic          cmd_valid,
  input wire ssti_cmd_t     cmd,
  input wire ssti_ccr_t     ccr,
  input wire logic          busy,
  input wire logic          done,
  input wire logic          illegal,
  input wire logic          mem_req,
  input wire ssti_mem_cmd_t mem_cmd,
  input wire logic          mem_ack,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tk;
  logic qk;
  logic sx;
  assign tk = cmd_valid && !busy && ce;
  assign qk = tk && cmd.op[15:12] == 4'h5 && cmd.op[8];
  assign sx = tk && cmd.op[15:12] == 4'h9 && cmd.op[8] && cmd.op[7:6] != 2'h3 && !cmd.op[5:4];
  a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_req_hold: assert property (ce && mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("memory request dropped early");
  a_done_alone: assert property (done |-> !busy && !illegal)
    else $error("done beside busy or illegal");
  a_quick_xc:
    assert property (qk && cmd.op[7:6] != 2'h3 && !cmd.op[5:3] |=> done && ccr.x == ccr.c)
    else $error("quick subtract extend differs from carry");
  a_quick_bad:
    assert property (qk && (cmd.op[7:3] == 5'h01 || cmd.op[5:0] inside {6'h3a, 6'h3b, 6'h3c})
      |=> illegal && !done) else $error("bad quick destination accepted");
  a_extend_z:
    assert property (sx && !cmd.op[3] |=> done && (!ccr.z || $past(ccr.z)) && ccr.x == ccr.c)
    else $error("extended subtract set zero");
  a_extend_mem:
    assert property (sx && cmd.op[3] |=> busy && mem_req && !mem_cmd.we)
    else $error("memory form did not start with a read");
  a_swap_flags:
    assert property (tk && cmd.op[15:3] == 13'h0908 |=> done && !ccr.v && !ccr.c
      && ccr.x == $past(ccr.x)) else $error("swap flags wrong");
  a_interp_flags:
    assert property (tk && cmd.op[15:3] == 13'h1f00 |=> !done || !ccr.c
      && ccr.x == $past(ccr.x)) else $error("interpolation flags wrong");
  c_swap: cover property (tk && cmd.op[15:3] == 13'h0908);
  c_wback: cover property (mem_ack && mem_cmd.we);
  c_reject: cover property (illegal);
endmodule : ssti_exec_asserts

// ---- testbench/ssti_mem_model.sv ----
// Operand memory partner: big-endian bytes, acknowledge after a set wait
`timescale 1ns/100ps
module ssti_mem_model
  import ssti_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic [3:0]    lat,
  input  wire logic          mem_req,
  input  wire ssti_mem_cmd_t mem_cmd,
  output logic               mem_ack,
  output logic [31:0]        mem_rdata
);
  logic [7:0]  mem [256];
  logic [3:0]  wait_ff;
  logic [31:0] r;
  int          n;
  // Data toggles outside the acknowledge so a stale capture shows up
  always @(posedge ref_clk)
  begin
    n = 1 << mem_cmd.size;
    r = 32'h0;
    mem_ack <= 1'b0;
    mem_rdata <= rst ? 32'h5a5a_5a5a : ~mem_rdata;
    wait_ff <= 4'h0;
    if (!rst && mem_req && !mem_ack && wait_ff < lat)
      wait_ff <= wait_ff + 4'h1;
    else if (!rst && mem_req && !mem_ack)
    begin
      mem_ack <= 1'b1;
      for (int i = 0; i < n; i++)
        if (mem_cmd.we)
          mem[8'(mem_cmd.addr + i)] <= mem_cmd.wdata[8 * (n - 1 - i) +: 8];
        else
          r = {r[23:0], mem[8'(mem_cmd.addr + i)]};
      if (!mem_cmd.we)
        mem_rdata <= r;
    end
  end
endmodule : ssti_mem_model

// ---- testbench/tb.sv ----
// Directed bench for the subtract/swap/interpolate datapath
`timescale 1ns/100ps
`include "ssti_regs.svh"
module tb
  import ssti_pkg::*;
;
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  logic          ce = 1'b1;
  logic          cmd_valid = 1'b0;
  ssti_cmd_t     cmd = '0;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [7:0]    reg_addr = 8'h00;
  logic [31:0]   reg_wdata = 32'h0;
  logic [3:0]    lat = 4'h0;
  ssti_ccr_t     ccr;
  ssti_mem_cmd_t mem_cmd;
  logic          busy, done, illegal, mem_req, mem_ack, ill;
  logic [31:0]   mem_rdata, reg_rdata;
  logic [15:0]   bad [4] = '{16'h5309, 16'h53bc, 16'h53ba, 16'h53c0};
  int            err_total = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  always #10 ref_clk = ~ref_clk;
  ssti_exec DUT (.ref_clk(ref_clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .ccr(ccr), .busy(busy), .done(done), .illegal(illegal), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ssti_mem_model mem_u (.ref_clk(ref_clk), .rst(rst), .lat(lat), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic ck(input string what, input logic [7:0] a, input logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(what, exp, reg_rdata);
    @(posedge ref_clk);
  endtask : ck
  // Waits for done or reject under a bound; memory forms may take many cycles
  task automatic run(input logic [15:0] op, input logic [15:0] ext, input logic [31:0] ea);
    int k = 0;
    cmd_valid <= 1'b1;
    cmd <= '{op: op, ext: ext, ea: ea};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    do
      @(negedge ref_clk);
    while (done !== 1'b1 && illegal !== 1'b1 && ++k < 300);
    ill = illegal;
    chk("completion", 32'h1, {31'h0, k < 300});
    @(posedge ref_clk);
  endtask : run
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    ck("ccr", `SSTI_OFS_CCR, 32'h0);
    ck("unmapped", 8'h80, 32'h0);
    // A write offered while the enable is low must not land
    ce <= 1'b0;
    wr(8'h18, 32'h77);
    ce <= 1'b1;
    ck("frozen d6", 8'h18, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, 32'h5);
      run({8'h51, i[1:0], 6'h00}, 16'h0, 32'h0);
      ck("d0", 8'h00, i == 0 ? 32'hfd : i == 1 ? 32'hfffd : 32'hfffffffd);
      ck("ccr", `SSTI_OFS_CCR, 32'h19);
    end
    wr(8'h00, 32'h3);
    run(16'h5780, 16'h0, 32'h0);
    ck("d0", 8'h00, 32'h0);
    ck("ccr", `SSTI_OFS_CCR, 32'h04);
    wr(`SSTI_OFS_CCR, 32'h0a);
    run(16'h5349, 16'h0, 32'h0);
    ck("a1", 8'h24, 32'hffffffff);
    ck("ccr", `SSTI_OFS_CCR, 32'h0a);
    foreach (bad[k])
    begin
      run(bad[k], 16'h0, 32'h0);
      chk("reject", 32'h1, {31'h0, ill});
    end
    ck("status", `SSTI_OFS_STAT, 32'h2);
    wr(`SSTI_OFS_STAT, 32'h2);
    ck("status", `SSTI_OFS_STAT, 32'h0);
    mem_u.mem[8'h50] = 8'h00;
    mem_u.mem[8'h51] = 8'h01;
    lat <= 4'h2;
    run(16'h5379, 16'h0, 32'h50);
    chk("mem", 32'h0, {16'h0, mem_u.mem[8'h50], mem_u.mem[8'h51]});
    wr(`SSTI_OFS_CCR, 32'h14);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h2);
    run(16'h9380, 16'h0, 32'h0);
    ck("d1", 8'h04, 32'h0);
    ck("ccr", `SSTI_OFS_CCR, 32'h04);
    wr(8'h04, 32'h1);
    run(16'h9380, 16'h0, 32'h0);
    ck("d1", 8'h04, 32'hffffffff);
    ck("ccr", `SSTI_OFS_CCR, 32'h19);
    wr(`SSTI_OFS_CCR, 32'h0);
    wr(8'h20, 32'h14);
    wr(8'h24, 32'h24);
    mem_u.mem[8'h12] = 8'h00;
    mem_u.mem[8'h13] = 8'h03;
    mem_u.mem[8'h22] = 8'h00;
    mem_u.mem[8'h23] = 8'h10;
    lat <= 4'h3;
    run(16'h9348, 16'h0, 32'h0);
    chk("mem", 32'hd, {16'h0, mem_u.mem[8'h22], mem_u.mem[8'h23]});
    ck("a0", 8'h20, 32'h12);
    ck("a1", 8'h24, 32'h22);
    wr(`SSTI_OFS_CCR, 32'h1f);
    wr(8'h08, 32'h80001234);
    run(16'h4842, 16'h0, 32'h0);
    ck("d2", 8'h08, 32'h12348000);
    ck("ccr", `SSTI_OFS_CCR, 32'h10);
    wr(`SSTI_OFS_CCR, 32'h11);
    wr(8'h0c, 32'habcd7f80);
    wr(8'h10, 32'h10);
    wr(8'h14, 32'h20);
    run(16'hf804, 16'h3845, 32'h0);
    ck("d3", 8'h0c, 32'habcd0018);
    ck("ccr", `SSTI_OFS_CCR, 32'h10);
    wr(8'h0c, 32'h7f80);
    run(16'hf804, 16'h3c45, 32'h0);
    ck("d3", 8'h0c, 32'h1800);
    wr(`SSTI_OFS_CCR, 32'h0);
    wr(8'h0c, 32'h240);
    mem_u.mem[8'h42] = 8'hf0;
    mem_u.mem[8'h43] = 8'h10;
    lat <= 4'h1;
    run(16'hf839, 16'h3900, 32'h40);
    ck("d3", 8'h0c, 32'h2f8);
    ck("ccr", `SSTI_OFS_CCR, 32'h08);
    results();
  end
endmodule : tb
bind ssti_exec ssti_exec_asserts chk_u (.ref_clk(ref_clk), .rst(rst), .ce(ce),
  .cmd_valid(cmd_valid), .cmd(cmd), .ccr(ccr), .busy(busy), .done(done), .illegal(illegal),
  .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));
